//--- verilog/bst_tap.sv
// Boundary-scan test port sampled on the system clock, with its TDO FIFO
// Function
// R1: Board ties test clock low when unused
// R2: Test data and select inputs pulled up
// R3: Sample on clock rise, drive on fall
// R4: State machine steered by select each rise
// R5: Shift in at MSB, out at LSB
// R6: Output driver on only in shift states
// R7: Five high select edges force reset state
// R8: Idle holds while select stays low
// R9: Data registers hold in data select state
// R10: Capture loads selected register, pins latched
// R11: Shift one bit per test clock
// R12: Pause and second exit resume shifting
// R13: External test outputs change only in update
// R14: Eight-bit instruction effective at update
// R15: Reset loads identification instruction
// R16: Instruction capture loads pattern 01
// R17: Port reset never disturbs memory operation
// R18: Power-up reset leaves output high-impedance
// R19: Exactly one register between TDI and TDO
// R20: Bypass bit, cleared when bypass runs
// R21: Pin chain is 113 bits long
// R22: Hardwired 32-bit identification code captured
// R23: Identification bit 0 reads one
// R24: All sixteen standard controller states
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module bst_fifo #(
	parameter int W     = `BST_TDO_W,
	parameter int DEPTH = `BST_FIFO_DEPTH
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
	logic         push, pop;

	assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign out_valid = wp_q != rp_q;
	assign out_data  = mem_q[rp_q[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		wp_d = push ? wp_q + (AW+1)'(1) : wp_q;
		rp_d = pop ? rp_q + (AW+1)'(1) : rp_q;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// Storage has no reset, only valid words are read
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end
endmodule // bst_fifo

module bst_tap
	import bst_pkg::*;
#(
	parameter logic [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT,
	parameter int                   BSR_W   = `BST_BSR_W
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             tck,
	input  wire logic             tms,
	input  wire logic             tdi,
	output logic                  tdo_o,
	output logic                  tdo_oe,
	input  wire logic [BSR_W-1:0] pin_levels,
	output logic [BSR_W-1:0]      scan_out,
	output logic                  drive_from_scan,
	output logic                  outputs_hiz
);
	localparam int IR_W = `BST_IR_W;
	localparam int ID_W = `BST_ID_W;

	// Synchronisers; idle level of select and data is high as if pulled up
	logic tck_m, tck_s, tck_p, tms_m, tms_s, tdi_m, tdi_s;
	logic tck_rise, tck_fall, rise_ok;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tck_m <= 1'b0;
			tck_s <= 1'b0;
			tck_p <= 1'b0;
			tms_m <= 1'b1; // see R2
			tms_s <= 1'b1; // see R2
			tdi_m <= 1'b1; // see R2
			tdi_s <= 1'b1; // see R2
		end else begin
			tck_m <= tck;
			tck_s <= tck_m;
			tck_p <= tck_s;
			tms_m <= tms;
			tms_s <= tms_m;
			tdi_m <= tdi;
			tdi_s <= tdi_m;
		end
	end

	assign tck_rise = tck_s & ~tck_p; // see R3
	assign tck_fall = ~tck_s & tck_p; // see R3

	// Pins pass two flops; a pin moving at capture may land either way
	logic [BSR_W-1:0] pin_m_q, pin_s_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_m_q <= '0;
			pin_s_q <= '0;
		end else begin
			pin_m_q <= pin_levels;
			pin_s_q <= pin_m_q;
		end
	end

	function automatic bst_path_t path_of(input logic [IR_W-1:0] op);
		unique case (op)
			`BST_OP_EXTEST,
			`BST_OP_SAMPLE: path_of = BST_PATH_BSR;
			`BST_OP_IDCODE: path_of = BST_PATH_ID;
			default:        path_of = BST_PATH_BYP;
		endcase
	endfunction

	function automatic logic is_shift(input bst_state_t s);
		is_shift = (s == BST_SHF_DR) || (s == BST_SHF_IR);
	endfunction

	// Controller
	bst_state_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (rise_ok) begin
			unique case (st_q) // see R4, R24
				BST_TLR:    st_d = tms_s ? BST_TLR : BST_RTI; // see R7
				BST_RTI:    st_d = tms_s ? BST_SEL_DR : BST_RTI; // see R8
				BST_SEL_DR: st_d = tms_s ? BST_SEL_IR : BST_CAP_DR;
				BST_CAP_DR: st_d = tms_s ? BST_EX1_DR : BST_SHF_DR;
				BST_SHF_DR: st_d = tms_s ? BST_EX1_DR : BST_SHF_DR;
				BST_EX1_DR: st_d = tms_s ? BST_UPD_DR : BST_PAU_DR;
				BST_PAU_DR: st_d = tms_s ? BST_EX2_DR : BST_PAU_DR; // see R12
				BST_EX2_DR: st_d = tms_s ? BST_UPD_DR : BST_SHF_DR; // see R12
				BST_UPD_DR: st_d = tms_s ? BST_SEL_DR : BST_RTI;
				BST_SEL_IR: st_d = tms_s ? BST_TLR : BST_CAP_IR;
				BST_CAP_IR: st_d = tms_s ? BST_EX1_IR : BST_SHF_IR;
				BST_SHF_IR: st_d = tms_s ? BST_EX1_IR : BST_SHF_IR;
				BST_EX1_IR: st_d = tms_s ? BST_UPD_IR : BST_PAU_IR;
				BST_PAU_IR: st_d = tms_s ? BST_EX2_IR : BST_PAU_IR;
				BST_EX2_IR: st_d = tms_s ? BST_UPD_IR : BST_SHF_IR;
				BST_UPD_IR: st_d = tms_s ? BST_SEL_DR : BST_RTI;
			endcase
		end
	end

	// Registers
	logic [IR_W-1:0]  ir_q, ir_d, irs_q, irs_d;
	logic             byp_q, byp_d;
	logic [BSR_W-1:0] bsr_q, bsr_d, bout_q, bout_d;
	logic [ID_W-1:0]  id_q, id_d;
	bst_path_t        path;

	assign path = path_of(ir_q); // see R19

	always_comb begin
		ir_d   = ir_q;
		irs_d  = irs_q;
		byp_d  = byp_q;
		bsr_d  = bsr_q;
		bout_d = bout_q;
		id_d   = id_q;
		if (rise_ok) begin
			unique case (st_q)
				BST_CAP_IR: irs_d = {irs_q[IR_W-1:2], `BST_IR_CAPTURE}; // see R16
				BST_SHF_IR: irs_d = {tdi_s, irs_q[IR_W-1:1]}; // see R5, R14
				BST_UPD_IR: ir_d = irs_q; // see R14
				BST_CAP_DR: begin // see R10
					unique case (path)
						BST_PATH_BYP: byp_d = 1'b0; // see R20
						BST_PATH_BSR: bsr_d = pin_s_q; // see R21
						BST_PATH_ID:  id_d = ID_CODE; // see R22, R23
					endcase
				end
				BST_SHF_DR: begin // see R5, R11
					unique case (path)
						BST_PATH_BYP: byp_d = tdi_s; // see R20
						BST_PATH_BSR: bsr_d = {tdi_s, bsr_q[BSR_W-1:1]};
						BST_PATH_ID:  id_d = {tdi_s, id_q[ID_W-1:1]};
					endcase
				end
				BST_UPD_DR: begin
					if (path == BST_PATH_BSR) begin
						bout_d = bsr_q; // see R13
					end
				end
				default: ; // Select and pause states hold, see R9
			endcase
			if (st_d == BST_TLR) begin
				ir_d = `BST_OP_IDCODE; // see R15
			end
		end
	end

	// Only this port is reset here; memory logic never sees it, see R17
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= BST_TLR; // see R18
			ir_q   <= `BST_OP_IDCODE; // see R15
			irs_q  <= '0;
			byp_q  <= 1'b0;
			bsr_q  <= '0;
			bout_q <= '0;
			id_q   <= '0;
		end else begin
			st_q   <= st_d;
			ir_q   <= ir_d;
			irs_q  <= irs_d;
			byp_q  <= byp_d;
			bsr_q  <= bsr_d;
			bout_q <= bout_d;
			id_q   <= id_d;
		end
	end

	assign scan_out        = bout_q;
	assign drive_from_scan = (ir_q == `BST_OP_EXTEST) ||
	                         (ir_q == `BST_OP_CLAMP);
	assign outputs_hiz     = ir_q == `BST_OP_HIGHZ;

	// Beat for TDO is formed at the rise and driven at the next fall
	bst_tdo_t  beat_in, beat_out;
	bst_path_t path_n;
	logic      fifo_rdy, beat_vld;

	assign path_n = path_of(ir_d);

	always_comb begin
		beat_in.oe = is_shift(st_d); // see R6
		if (st_d == BST_SHF_IR) begin
			beat_in.bit_v = irs_d[0];
		end else begin
			unique case (path_n) // see R19
				BST_PATH_BYP: beat_in.bit_v = byp_d;
				BST_PATH_BSR: beat_in.bit_v = bsr_d[0];
				BST_PATH_ID:  beat_in.bit_v = id_d[0];
				default:      beat_in.bit_v = byp_d;
			endcase
		end
	end

	// A full FIFO stalls the controller rather than losing a beat
	assign rise_ok = tck_rise & fifo_rdy;

	bst_fifo #(
		.W     (`BST_TDO_W),
		.DEPTH (`BST_FIFO_DEPTH)
	) u_tdo_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_data   (beat_in),
		.in_valid  (rise_ok),
		.in_ready  (fifo_rdy),
		.out_data  (beat_out),
		.out_valid (beat_vld),
		.out_ready (tck_fall)
	);

	logic tdo_q, tdo_d, oe_q, oe_d, pop;

	assign pop = beat_vld & tck_fall;

	always_comb begin
		tdo_d = tdo_q;
		oe_d  = oe_q;
		if (pop) begin // see R3
			tdo_d = beat_out.bit_v;
			oe_d  = beat_out.oe; // see R6
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tdo_q <= 1'b0;
			oe_q  <= 1'b0; // see R18
		end else begin
			tdo_q <= tdo_d;
			oe_q  <= oe_d;
		end
	end

	assign tdo_o  = tdo_q;
	assign tdo_oe = oe_q;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic [2:0] hi_cnt_q, hi_cnt_d;

	always_comb begin
		hi_cnt_d = hi_cnt_q;
		if (rise_ok) begin
			if (!tms_s) begin
				hi_cnt_d = 3'h0;
			end else if (hi_cnt_q != `BST_RESET_EDGES) begin
				hi_cnt_d = hi_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt_q <= 3'h0;
		end else begin
			hi_cnt_q <= hi_cnt_d;
		end
	end

	tlr_five_a: assert property ( // see R7
		hi_cnt_q == `BST_RESET_EDGES |-> st_q == BST_TLR)
		else $error("five high select edges did not reach reset state");
	tdo_enable_a: assert property ( // see R6
		pop |=> tdo_oe == is_shift(st_q))
		else $error("TDO enable does not match shift state");
	tdo_fall_a: assert property ( // see R3
		$changed(tdo_oe) |-> $past(tck_fall))
		else $error("TDO enable changed away from a falling edge");
	ir_reset_a: assert property ( // see R15
		st_q == BST_TLR |-> ir_q == `BST_OP_IDCODE)
		else $error("reset state without identification instruction");
	ir_update_a: assert property ( // see R14
		$changed(ir_q) |->
		$past(st_q) == BST_UPD_IR || st_q == BST_TLR)
		else $error("instruction changed outside update");
	ir_capture_a: assert property ( // see R16
		rise_ok && st_q == BST_CAP_IR |=> irs_q[1:0] == `BST_IR_CAPTURE)
		else $error("instruction capture pattern wrong");
	ir_shift_a: assert property ( // see R5
		rise_ok && st_q == BST_SHF_IR |=>
		irs_q == {$past(tdi_s), $past(irs_q[IR_W-1:1])})
		else $error("instruction shift wrong");
	scan_out_a: assert property ( // see R13
		$changed(scan_out) |-> $past(st_q) == BST_UPD_DR)
		else $error("parallel scan outputs changed outside update");
	sel_hold_a: assert property ( // see R9
		st_q == BST_SEL_DR |=>
		$stable(bsr_q) && $stable(id_q) && $stable(byp_q))
		else $error("data register changed in select state");
	bsr_shift_a: assert property ( // see R11
		rise_ok && st_q == BST_SHF_DR && path == BST_PATH_BSR |=>
		bsr_q == {$past(tdi_s), $past(bsr_q[BSR_W-1:1])})
		else $error("pin chain shift wrong");
	byp_clear_a: assert property ( // see R20
		rise_ok && st_q == BST_CAP_DR && path == BST_PATH_BYP |=>
		byp_q == 1'b0)
		else $error("bypass bit not cleared");
	id_capture_a: assert property ( // see R22
		rise_ok && st_q == BST_CAP_DR && path == BST_PATH_ID |=>
		id_q == ID_CODE && id_q[0])
		else $error("identification code not captured");
	idle_hold_a: assert property ( // see R8
		rise_ok && st_q == BST_RTI && !tms_s |=> st_q == BST_RTI)
		else $error("idle state left with select low");

	shift_dr_c: cover property (rise_ok && st_q == BST_SHF_DR);
	resume_c: cover property (st_q == BST_EX2_DR ##[1:40] st_q == BST_SHF_DR);
	upd_ir_c: cover property (rise_ok && st_q == BST_UPD_IR);
	extest_c: cover property ($changed(scan_out));
endmodule // bst_tap

`default_nettype wire

//--- common/bst_consts.svh
// Constants of the boundary-scan test port
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

`define BST_IR_W       8
`define BST_BSR_W      113
`define BST_ID_W       32
`define BST_FIFO_DEPTH 4
`define BST_TDO_W      2

// Instruction codes, all other codes act as bypass
`define BST_OP_EXTEST  8'h00
`define BST_OP_IDCODE  8'h01
`define BST_OP_SAMPLE  8'h05
`define BST_OP_CLAMP   8'h07
`define BST_OP_HIGHZ   8'h08
`define BST_OP_BYPASS  8'hFF

// Capture pattern for the instruction shift stage
`define BST_IR_CAPTURE 2'h1
// Identification code, value arbitrary, bit 0 set
`define BST_ID_DEFAULT 32'h1000_2001
// Rising edges with select high that force the reset state
`define BST_RESET_EDGES 3'h5

`endif

//--- common/bst_pkg.sv
// Types of the boundary-scan test port
`include "bst_consts.svh"

package bst_pkg;

	typedef enum logic [3:0] {
		BST_TLR    = 4'h0,
		BST_RTI    = 4'h1,
		BST_SEL_DR = 4'h3,
		BST_CAP_DR = 4'h2,
		BST_SHF_DR = 4'h6,
		BST_EX1_DR = 4'h7,
		BST_PAU_DR = 4'h5,
		BST_EX2_DR = 4'h4,
		BST_UPD_DR = 4'hC,
		BST_SEL_IR = 4'hD,
		BST_CAP_IR = 4'hF,
		BST_SHF_IR = 4'hE,
		BST_EX1_IR = 4'hA,
		BST_PAU_IR = 4'hB,
		BST_EX2_IR = 4'h9,
		BST_UPD_IR = 4'h8
	} bst_state_t;

	typedef enum logic [1:0] {
		BST_PATH_BYP = 2'h0,
		BST_PATH_BSR = 2'h1,
		BST_PATH_ID  = 2'h2
	} bst_path_t;

	// One output bit with its driver enable
	typedef struct packed {
		logic oe;
		logic bit_v;
	} bst_tdo_t;

endpackage

//--- tb/bst_jtag_ctl.sv
// Model of the board-level controller that drives the test port
`timescale 1ns/1ps
`default_nettype none

module bst_jtag_ctl (
	input  wire logic mclk,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_o,
	input  wire logic tdo_oe,
	output logic      got,
	output logic      got_bit
);
	// Parked like a board with pull-ups and a grounded clock
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		got = 1'h0;
		got_bit = 1'h0;
	end

	// One test clock of 32 ns; TDO read just before the fall,
	// where the bit from the previous fall still stands
	task automatic clk(input logic m, input logic d);
		@(posedge mclk);
		got <= 1'h0;
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge mclk);
		tck <= 1'h1;
		repeat (4) @(posedge mclk);
		tck <= 1'h0;
		got <= tdo_oe;
		// No pull-up on TDO; a released pin reads as the inverse
		got_bit <= tdo_oe ? tdo_o : ~tdo_o;
	endtask
endmodule // bst_jtag_ctl

`default_nettype wire

//--- tb/bst_tap_tb.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"

module bst_tap_tb;
	// Value arbitrary, bit 0 set
	localparam logic [31:0] ID_V = 32'h3C5A_0001;
	logic         mclk, rst_n, tck, tms, tdi, tdo_o, tdo_oe;
	logic         got, got_bit, drive_from_scan, outputs_hiz;
	logic         got_q = 1'h0;
	logic [112:0] pin_levels, scan_out, last_sc;
	logic [127:0] d;
	logic [7:0]   irs, irm;
	logic [7:0]   ops[4] = '{`BST_OP_HIGHZ, `BST_OP_BYPASS, 8'h3C,
		`BST_OP_CLAMP};
	logic [2:0]   q[$];
	logic [2:0]   ew;
	logic [31:0]  rs;
	int           failures, check_count, cyc;

	bst_tap #(.ID_CODE(ID_V)) i_bst_tap (
		.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .pin_levels(pin_levels),
		.scan_out(scan_out), .drive_from_scan(drive_from_scan),
		.outputs_hiz(outputs_hiz));

	bst_jtag_ctl i_bst_jtag_ctl (
		.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
		.tdo_oe(tdo_oe), .got(got), .got_bit(got_bit));

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic chk(input string n, input logic [127:0] e, s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wrap_up();
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// e: result expected, bit cared for, bit value
	task automatic step(input logic m, dd, input logic [2:0] e);
		if (e[2])
			q.push_back(e);
		i_bst_jtag_ctl.clk(m, dd);
	endtask

	// From idle to idle; pz marks the bit after which shifting pauses
	task automatic scan(input logic ir, input int n,
			input logic [127:0] di, ex, mk, input int pz);
		step(1'h1, 1'h1, 3'h0);
		if (ir)
			step(1'h1, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pz, di[i], {1'h1, mk[i], ex[i]});
			if (i == pz) begin
				step(1'h0, 1'h1, 3'h0);
				step(1'h0, 1'h1, 3'h0);
				chk("scan_out", last_sc, scan_out);
				step(1'h1, 1'h1, 3'h0);
				step(1'h0, 1'h1, 3'h0);
			end
		end
		step(1'h1, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
	endtask

	// Upper capture bits reset to zero but are not checked until the first scan fills them
	task automatic ir_load(input logic [7:0] op);
		scan(1'h1, 8, op, {irs[7:2], 2'h1}, irm, -1);
		irs = op;
		irm = 8'hFF;
	endtask

	always @(posedge mclk) begin
		got_q <= got;
		if (got === 1'h1 && got_q === 1'h0) begin
			ew = (q.size() > 0) ? q.pop_front() : 3'h0;
			if (ew[2] !== 1'h1)
				chk("tdo_oe", 1'h0, 1'h1);
			else if (ew[1])
				chk("tdo", ew[0], got_bit);
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		rst_n = 1'h0;
		pin_levels = '0;
		irs = 8'h0;
		irm = 8'h03;
		rs = 32'hF;
		last_sc = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		#1;
		chk("tdo_oe", 1'h0, tdo_oe);
		chk("scan_out", '0, scan_out);
		chk("drive_from_scan", 1'h0, drive_from_scan);
		step(1'h0, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
		d = {rnd(), rnd(), rnd(), rnd()};
		scan(1'h0, 32, d, ID_V, '1, -1);
		ir_load(`BST_OP_SAMPLE);
		d = {rnd(), rnd(), rnd(), rnd()};
		pin_levels <= d[112:0];
		scan(1'h0, 113, {d[60:0], d[127:61]}, d, '1, -1);
		d = {d[60:0], d[127:61]};
		last_sc = d[112:0];
		chk("scan_out", last_sc, scan_out);
		ir_load(`BST_OP_EXTEST);
		chk("drive_from_scan", 1'h1, drive_from_scan);
		d = {rnd(), rnd(), rnd(), rnd()};
		scan(1'h0, 113, d, pin_levels, '1, 50);
		chk("scan_out", d[112:0], scan_out);
		foreach (ops[k]) begin
			ir_load(ops[k]);
			chk("outputs_hiz", ops[k] == `BST_OP_HIGHZ, outputs_hiz);
			chk("drive_from_scan", ops[k] == `BST_OP_CLAMP, drive_from_scan);
			d = {rnd(), rnd(), rnd(), rnd()};
			scan(1'h0, 9, d, {d[126:0], 1'h0}, '1, -1);
		end
		// Five high edges from shift, the longest way to reset
		step(1'h1, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
		step(1'h0, 1'h1, 3'h0);
		step(1'h1, 1'h1, 3'h6);
		repeat (3) step(1'h1, 1'h1, 3'h0);
		chk("drive_from_scan", 1'h1, drive_from_scan);
		step(1'h1, 1'h1, 3'h0);
		chk("drive_from_scan", 1'h0, drive_from_scan);
		step(1'h0, 1'h1, 3'h0);
		scan(1'h0, 32, d, ID_V, '1, -1);
		// Port reset in mid-run clears the parallel outputs
		rst_n <= 1'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		#1;
		chk("scan_out", '0, scan_out);
		chk("tdo_oe", 1'h0, tdo_oe);
		step(1'h0, 1'h1, 3'h0);
		scan(1'h0, 32, d, ID_V, '1, -1);
		chk("tdo pending", 0, q.size());
		wrap_up();
	end
endmodule // bst_tap_tb

`default_nettype wire
